/* File: hw/crf_regfile.v */
`timescale 1ns/10ps
// Notes on behaviour
// - Vector base gives vector high byte, resets zero.
// - Low seven counter bits count opcode fetches.
// - Sixteen-bit stack pointer, cleared by reset.
// - Program counter advances per fetch, resets zero.
// - Indexed address adds signed displacement to index.
// - Sign flag copies result top bit.
// - Zero flag set on zero result.
// - Half carry records carry/borrow out of bit 3, or bit 11 for word ops.
// - Logic ops: parity flag set on even.
// - Arithmetic: same flag marks signed overflow.
// - Subtract flag set by subtraction-type operations.
// - Carry from top bit; rotates update it.
// - Three-bit code selects single byte registers.
// - HL/SP pair field decodes BC,DE,HL,SP.
// - Index fields decode index; accum field decodes AF.
// - High/low suffix picks upper/lower byte, except on AF pair writes.
// - Indirect address comes straight from BC/DE/HL.
// - Extended/immediate operands come from instruction.
// - Relative branch adds displacement to program counter.
// - First I/O form: operand low, accumulator high.
// - Second I/O form: B low, C high.
// - Third/fourth forms: operand or C, high zero.
// - Alternate AF and pairs swap with primary.

`include "crf_defines.vh"

module crf_regfile (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Instruction sequencing.
  input wire opcode_fetch_cycle,
  input wire rel_branch,
  input wire [7:0] rel_disp,
  input wire pc_load,
  input wire [15:0] pc_load_val,
  input wire exchange_sets,
  // Byte and pair writes.
  input wire byte_we,
  input wire [2:0] byte_sel,
  input wire [7:0] byte_wdata,
  input wire pair_we,
  input wire [1:0] pair_kind,
  input wire [1:0] pair_code,
  input wire pair_half_en,
  input wire pair_half_hi,
  input wire [15:0] pair_wdata,
  // Flag update from the arithmetic unit.
  input wire flag_upd,
  input wire [1:0] alu_kind,
  input wire alu_word,
  input wire [15:0] alu_a,
  input wire [15:0] alu_b,
  input wire [15:0] alu_res,
  input wire rot_carry,
  // Operand and I/O address generation.
  input wire ea_req,
  input wire [1:0] ea_mode,
  input wire ea_second_index,
  input wire [7:0] ea_disp,
  input wire [15:0] ea_imm,
  input wire io_req,
  input wire [1:0] io_form,
  input wire [7:0] io_operand,
  input wire [7:0] vec_low,
  // Results.
  output reg [15:0] addr_out,
  output reg addr_valid,
  output reg io_request_strobe_n,
  output reg [15:0] vec_addr,
  output reg [7:0] byte_rd,
  output reg [15:0] pair_rd,
  output reg [7:0] accum_out,
  output reg [7:0] condition_flags_out
);

  // ****************************************************************
  // Register state
  // ****************************************************************

  // Primary set: accumulator, flags and the three general pairs.
  reg [7:0] acc_reg;
  reg [7:0] condition_flags_reg;
  reg [15:0] bc_reg;
  reg [15:0] de_reg;
  reg [15:0] hl_reg;
  // Alternate set, reachable only by exchange.
  reg [7:0] acc_alt_reg;
  reg [7:0] flags_alt_reg;
  reg [15:0] bc_alt_reg;
  reg [15:0] de_alt_reg;
  reg [15:0] hl_alt_reg;
  // Special registers.
  reg [7:0] vec_base_reg;
  reg [7:0] fetch_count_reg;
  reg [15:0] ix_reg;
  reg [15:0] iy_reg;
  reg [15:0] stack_pointer_reg;
  reg [15:0] program_counter_reg;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Reads a 16-bit pair through one of the four two-bit fields.
  function [15:0] pair_read;
    input [1:0] kind;
    input [1:0] code;
    input [15:0] bc;
    input [15:0] de;
    input [15:0] hl;
    input [15:0] ix;
    input [15:0] iy;
    input [15:0] sp;
    input [15:0] af;
    begin
      case (code)
        2'h0: pair_read = bc;
        2'h1: pair_read = de;
        2'h2: begin
          case (kind)
            `CRF_KIND_FIRST: pair_read = ix;
            `CRF_KIND_SECOND: pair_read = iy;
            default: pair_read = hl;
          endcase
        end
        default: pair_read = (kind == `CRF_KIND_ACCF) ? af : sp;
      endcase
    end
  endfunction

  // Replaces one byte of a word, or all of it, as a write asks.
  function [15:0] merge_half;
    input [15:0] old;
    input [15:0] wdata;
    input half_en;
    input half_hi;
    begin
      if (!half_en) begin
        merge_half = wdata;
      end else if (half_hi) begin
        merge_half = {wdata[7:0], old[7:0]};
      end else begin
        merge_half = {old[15:8], wdata[7:0]};
      end
    end
  endfunction

  // ****************************************************************
  // Flag computation
  // ****************************************************************

  reg [16:0] sum_w;
  reg [15:0] res_w;
  reg top_a;
  reg top_b;
  reg top_r;
  reg [7:0] flags_next;

  // Forms the new flag byte; bits 5 and 3 keep their stored value.
  always @* begin
    if (alu_kind == `CRF_ALU_SUB) begin
      sum_w = {1'b0, alu_a} - {1'b0, alu_b};
    end else begin
      sum_w = {1'b0, alu_a} + {1'b0, alu_b};
    end
    if (alu_kind == `CRF_ALU_ADD || alu_kind == `CRF_ALU_SUB) begin
      res_w = sum_w[15:0];
    end else begin
      res_w = alu_res;
    end
    top_a = alu_word ? alu_a[15] : alu_a[7];
    top_b = alu_word ? alu_b[15] : alu_b[7];
    top_r = alu_word ? res_w[15] : res_w[7];
    flags_next = condition_flags_reg;
    flags_next[`CRF_FL_SIGN] = top_r;
    if (alu_word) begin
      flags_next[`CRF_FL_ZERO] = (res_w == 16'h0000);
      flags_next[`CRF_FL_HALF] = alu_a[12] ^ alu_b[12] ^ res_w[12];
    end else begin
      flags_next[`CRF_FL_ZERO] = (res_w[7:0] == 8'h00);
      flags_next[`CRF_FL_HALF] = alu_a[4] ^ alu_b[4] ^ res_w[4];
    end
    case (alu_kind)
      `CRF_ALU_ADD: begin
        // Overflow when like-signed operands give an unlike result.
        flags_next[`CRF_FL_PV] = (top_a == top_b) && (top_r != top_a);
        flags_next[`CRF_FL_SUB] = 1'b0;
        flags_next[`CRF_FL_CARRY] = alu_word ? sum_w[16] :
          (alu_a[8] ^ alu_b[8] ^ sum_w[8]);
      end
      `CRF_ALU_SUB: begin
        // Overflow when unlike-signed operands flip the minuend sign.
        flags_next[`CRF_FL_PV] = (top_a != top_b) && (top_r != top_a);
        flags_next[`CRF_FL_SUB] = 1'b1;
        flags_next[`CRF_FL_CARRY] = alu_word ? sum_w[16] :
          (alu_a[8] ^ alu_b[8] ^ sum_w[8]);
      end
      `CRF_ALU_LOGIC: begin
        // Even count of ones sets the flag.
        flags_next[`CRF_FL_PV] = ~(^res_w[7:0]);
      end
      default: begin
        // Shifts and rotates deliver their own carry.
        flags_next[`CRF_FL_CARRY] = rot_carry;
      end
    endcase
  end

  // ****************************************************************
  // Address generation
  // ****************************************************************

  reg [15:0] ea_next;
  reg [15:0] io_next;
  reg [15:0] index_sel;

  // Computes the operand address and the I/O address.
  always @* begin
    index_sel = ea_second_index ? iy_reg : ix_reg;
    case (ea_mode)
      `CRF_EA_INDIRECT: begin
        case (pair_code)
          2'h0: ea_next = bc_reg;
          2'h1: ea_next = de_reg;
          default: ea_next = hl_reg;
        endcase
      end
      `CRF_EA_INDEXED: begin
        ea_next = index_sel + {{8{ea_disp[7]}}, ea_disp};
      end
      `CRF_EA_EXTENDED: ea_next = ea_imm;
      default: ea_next = program_counter_reg;
    endcase
    case (io_form)
      `CRF_IO_OPER_ACC: io_next = {acc_reg, io_operand};
      `CRF_IO_B_C: io_next = {bc_reg[7:0], bc_reg[15:8]};
      `CRF_IO_OPER_ZERO: io_next = {8'h00, io_operand};
      default: io_next = {8'h00, bc_reg[7:0]};
    endcase
  end

  // Registers the address bus value; the I/O strobe is low in the cycle after each io_req cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_out <= `CRF_RST_WORD;
      addr_valid <= 1'b0;
      io_request_strobe_n <= 1'b1;
      vec_addr <= `CRF_RST_WORD;
    end else begin
      addr_valid <= ea_req | io_req;
      io_request_strobe_n <= ~io_req;
      if (io_req) begin
        addr_out <= io_next;
      end else if (ea_req) begin
        addr_out <= ea_next;
      end
      vec_addr <= {vec_base_reg, vec_low};
    end
  end

  // ****************************************************************
  // APB access
  // ****************************************************************

  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  reg [31:0] rd_mux;
  reg addr_hit;

  assign pready = 1'b1;

  // Decodes the byte address into read data and a hit flag.
  always @* begin
    addr_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `CRF_OFF_AF: rd_mux = {16'h0000, acc_reg, condition_flags_reg};
      `CRF_OFF_BC: rd_mux = {16'h0000, bc_reg};
      `CRF_OFF_DE: rd_mux = {16'h0000, de_reg};
      `CRF_OFF_HL: rd_mux = {16'h0000, hl_reg};
      `CRF_OFF_IX: rd_mux = {16'h0000, ix_reg};
      `CRF_OFF_IY: rd_mux = {16'h0000, iy_reg};
      `CRF_OFF_SP: rd_mux = {16'h0000, stack_pointer_reg};
      `CRF_OFF_PC: rd_mux = {16'h0000, program_counter_reg};
      `CRF_OFF_IR: rd_mux = {16'h0000, vec_base_reg, fetch_count_reg};
      default: addr_hit = 1'b0;
    endcase
  end

  // Captures read data and the error answer in the setup cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~addr_hit;
    end
  end

  // ****************************************************************
  // Register updates
  // ****************************************************************

  // Core operations first; an APB write in the same cycle wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= `CRF_RST_BYTE;
      condition_flags_reg <= `CRF_RST_BYTE;
      bc_reg <= `CRF_RST_WORD;
      de_reg <= `CRF_RST_WORD;
      hl_reg <= `CRF_RST_WORD;
      acc_alt_reg <= `CRF_RST_BYTE;
      flags_alt_reg <= `CRF_RST_BYTE;
      bc_alt_reg <= `CRF_RST_WORD;
      de_alt_reg <= `CRF_RST_WORD;
      hl_alt_reg <= `CRF_RST_WORD;
      vec_base_reg <= `CRF_RST_BYTE;
      fetch_count_reg <= `CRF_RST_BYTE;
      ix_reg <= `CRF_RST_WORD;
      iy_reg <= `CRF_RST_WORD;
      stack_pointer_reg <= `CRF_RST_WORD;
      program_counter_reg <= `CRF_RST_WORD;
    end else begin
      // Sequencing: fetch, then branch or load override.
      if (opcode_fetch_cycle) begin
        fetch_count_reg <= {fetch_count_reg[7],
          fetch_count_reg[6:0] + 7'h01};
        program_counter_reg <= program_counter_reg + 16'h0001;
      end
      if (rel_branch) begin
        program_counter_reg <= program_counter_reg +
          {{8{rel_disp[7]}}, rel_disp};
      end else if (pc_load) begin
        program_counter_reg <= pc_load_val;
      end
      // Swap primary and alternate sets.
      if (exchange_sets) begin
        acc_reg <= acc_alt_reg;
        acc_alt_reg <= acc_reg;
        condition_flags_reg <= flags_alt_reg;
        flags_alt_reg <= condition_flags_reg;
        bc_reg <= bc_alt_reg;
        bc_alt_reg <= bc_reg;
        de_reg <= de_alt_reg;
        de_alt_reg <= de_reg;
        hl_reg <= hl_alt_reg;
        hl_alt_reg <= hl_reg;
      end
      if (flag_upd) begin
        condition_flags_reg <= flags_next;
      end
      // Single byte write through the three-bit field.
      if (byte_we) begin
        case (byte_sel)
          `CRF_G_B: bc_reg[15:8] <= byte_wdata;
          `CRF_G_C: bc_reg[7:0] <= byte_wdata;
          `CRF_G_D: de_reg[15:8] <= byte_wdata;
          `CRF_G_E: de_reg[7:0] <= byte_wdata;
          `CRF_G_H: hl_reg[15:8] <= byte_wdata;
          `CRF_G_L: hl_reg[7:0] <= byte_wdata;
          `CRF_G_A: acc_reg <= byte_wdata;
          default: ;
        endcase
      end
      // Pair write through the two-bit field, whole or one half.
      if (pair_we) begin
        case (pair_code)
          2'h0: bc_reg <= merge_half(bc_reg, pair_wdata, pair_half_en,
            pair_half_hi);
          2'h1: de_reg <= merge_half(de_reg, pair_wdata, pair_half_en,
            pair_half_hi);
          2'h2: begin
            if (pair_kind == `CRF_KIND_FIRST) begin
              ix_reg <= merge_half(ix_reg, pair_wdata, pair_half_en,
                pair_half_hi);
            end else if (pair_kind == `CRF_KIND_SECOND) begin
              iy_reg <= merge_half(iy_reg, pair_wdata, pair_half_en,
                pair_half_hi);
            end else begin
              hl_reg <= merge_half(hl_reg, pair_wdata, pair_half_en,
                pair_half_hi);
            end
          end
          default: begin
            if (pair_kind == `CRF_KIND_ACCF) begin
              acc_reg <= pair_wdata[15:8];
              condition_flags_reg <= pair_wdata[7:0];
            end else begin
              stack_pointer_reg <= merge_half(stack_pointer_reg,
                pair_wdata, pair_half_en, pair_half_hi);
            end
          end
        endcase
      end
      // Software write over APB.
      if (apb_wr) begin
        case (paddr)
          `CRF_OFF_AF: begin
            acc_reg <= pwdata[15:8];
            condition_flags_reg <= pwdata[7:0];
          end
          `CRF_OFF_BC: bc_reg <= pwdata[15:0];
          `CRF_OFF_DE: de_reg <= pwdata[15:0];
          `CRF_OFF_HL: hl_reg <= pwdata[15:0];
          `CRF_OFF_IX: ix_reg <= pwdata[15:0];
          `CRF_OFF_IY: iy_reg <= pwdata[15:0];
          `CRF_OFF_SP: stack_pointer_reg <= pwdata[15:0];
          `CRF_OFF_PC: program_counter_reg <= pwdata[15:0];
          `CRF_OFF_IR: begin
            vec_base_reg <= pwdata[15:8];
            fetch_count_reg <= pwdata[7:0];
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Read ports toward the core
  // ****************************************************************

  reg [15:0] pair_sel_w;

  // Registers the selected byte, the selected pair and A and F.
  always @* begin
    pair_sel_w = pair_read(pair_kind, pair_code, bc_reg, de_reg, hl_reg,
      ix_reg, iy_reg, stack_pointer_reg, {acc_reg, condition_flags_reg});
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_rd <= `CRF_RST_BYTE;
      pair_rd <= `CRF_RST_WORD;
      accum_out <= `CRF_RST_BYTE;
      condition_flags_out <= `CRF_RST_BYTE;
    end else begin
      case (byte_sel)
        `CRF_G_B: byte_rd <= bc_reg[15:8];
        `CRF_G_C: byte_rd <= bc_reg[7:0];
        `CRF_G_D: byte_rd <= de_reg[15:8];
        `CRF_G_E: byte_rd <= de_reg[7:0];
        `CRF_G_H: byte_rd <= hl_reg[15:8];
        `CRF_G_L: byte_rd <= hl_reg[7:0];
        `CRF_G_A: byte_rd <= acc_reg;
        default: byte_rd <= 8'h00;
      endcase
      if (pair_half_en) begin
        pair_rd <= {8'h00, pair_half_hi ? pair_sel_w[15:8] :
          pair_sel_w[7:0]};
      end else begin
        pair_rd <= pair_sel_w;
      end
      accum_out <= acc_reg;
      condition_flags_out <= condition_flags_reg;
    end
  end

endmodule // crf_regfile

/* File: hw/crf_defines.vh */
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH

// APB register byte offsets.
`define CRF_OFF_AF 8'h00
`define CRF_OFF_BC 8'h04
`define CRF_OFF_DE 8'h08
`define CRF_OFF_HL 8'h0c
`define CRF_OFF_IX 8'h10
`define CRF_OFF_IY 8'h14
`define CRF_OFF_SP 8'h18
`define CRF_OFF_PC 8'h1c
`define CRF_OFF_IR 8'h20

// Field positions inside condition_flags.
`define CRF_FL_SIGN 7
`define CRF_FL_ZERO 6
`define CRF_FL_HALF 4
`define CRF_FL_PV 2
`define CRF_FL_SUB 1
`define CRF_FL_CARRY 0

// Reset values.
`define CRF_RST_BYTE 8'h00
`define CRF_RST_WORD 16'h0000

// Byte register select codes.
`define CRF_G_B 3'h0
`define CRF_G_C 3'h1
`define CRF_G_D 3'h2
`define CRF_G_E 3'h3
`define CRF_G_H 3'h4
`define CRF_G_L 3'h5
`define CRF_G_A 3'h7

// Pair select field kinds.
`define CRF_KIND_HL_SP 2'h0
`define CRF_KIND_FIRST 2'h1
`define CRF_KIND_SECOND 2'h2
`define CRF_KIND_ACCF 2'h3

// Flag update kinds.
`define CRF_ALU_ADD 2'h0
`define CRF_ALU_SUB 2'h1
`define CRF_ALU_LOGIC 2'h2
`define CRF_ALU_ROT 2'h3

// Operand address modes.
`define CRF_EA_INDIRECT 2'h0
`define CRF_EA_INDEXED 2'h1
`define CRF_EA_EXTENDED 2'h2
`define CRF_EA_IMMED 2'h3

// I/O address forms.
`define CRF_IO_OPER_ACC 2'h0
`define CRF_IO_B_C 2'h1
`define CRF_IO_OPER_ZERO 2'h2
`define CRF_IO_C_ZERO 2'h3

`endif

/* File: verification/crf_regfile_chk.sv */
`timescale 1ns/10ps
// ******************************************
// Port checker for the register file.
// ******************************************
module crf_regfile_chk (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Core requests.
  input wire ea_req,
  input wire [1:0] ea_mode,
  input wire [15:0] ea_imm,
  input wire io_req,
  input wire [1:0] io_form,
  input wire [7:0] io_operand,
  input wire [7:0] vec_low,
  input wire flag_upd,
  input wire [1:0] alu_kind,
  input wire [15:0] alu_res,
  input wire rot_carry,
  // Results.
  input wire [15:0] addr_out,
  input wire addr_valid,
  input wire io_request_strobe_n,
  input wire [15:0] vec_addr,
  input wire [7:0] condition_flags_out
);
  // Low byte of the result, the part that logic flags look at.
  wire [7:0] res_lo = alu_res[7:0];

  // Everything runs on the bus clock and rests during reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_io_high_zero: assert property (
    io_req && io_form[1] |=> addr_out[15:8] == 8'h00)
    else $error("I/O high byte not zero");
  a_io_oper_low: assert property (
    io_req && !io_form[0] |=> addr_out[7:0] == $past(io_operand))
    else $error("I/O low byte is not the operand");
  a_strobe_cause: assert property (
    io_request_strobe_n == !$past(io_req))
    else $error("I/O strobe not one cycle after request");
  a_valid_cause: assert property (
    addr_valid == $past(ea_req || io_req))
    else $error("address valid without request");
  a_ext_addr: assert property (
    ea_req && !io_req && ea_mode == 2'h2 |=> addr_out == $past(ea_imm))
    else $error("extended address not from instruction");
  a_vec_low: assert property (
    presetn |=> vec_addr[7:0] == $past(vec_low))
    else $error("vector low byte wrong");
  a_logic_flags: assert property (
    flag_upd && alu_kind == 2'h2 ##1 !flag_upd |=>
      condition_flags_out[7] == $past(res_lo[7], 2) &&
      condition_flags_out[6] == ($past(res_lo, 2) == 8'h00) &&
      condition_flags_out[2] == ~^$past(res_lo, 2))
    else $error("logic flags wrong");
  a_rot_carry: assert property (
    flag_upd && alu_kind == 2'h3 ##1 !flag_upd |=>
      condition_flags_out[0] == $past(rot_carry, 2))
    else $error("rotate carry wrong");

  // Main scenarios.
  c_io: cover property (io_req && io_form == 2'h1);
  c_logic: cover property (flag_upd && alu_kind == 2'h2);
  c_indexed: cover property (ea_req && ea_mode == 2'h1);
endmodule // crf_regfile_chk

/* File: verification/crf_regfile_bench.sv */
`timescale 1ns/10ps
`include "crf_defines.vh"
// ******************************************
// Self-checking bench for the register file.
// ******************************************
module crf_regfile_bench;
  // Bus and core inputs; strb holds one bit per core request kind.
  reg pclk, presetn, psel, penable, pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg [8:0] strb;
  reg [7:0] rel_disp, byte_wdata, ea_disp, io_operand, vec_low;
  reg [2:0] byte_sel;
  reg [1:0] pair_kind, pair_code, alu_kind, ea_mode, io_form;
  reg pair_half_en, pair_half_hi, alu_word, rot_carry, ea_second_index;
  reg [15:0] pc_load_val, pair_wdata, alu_a, alu_b, alu_res, ea_imm;
  // Design outputs.
  wire [31:0] prdata;
  wire pready, pslverr, addr_valid, io_request_strobe_n;
  wire [15:0] addr_out, vec_addr, pair_rd;
  wire [7:0] byte_rd, accum_out, condition_flags_out;
  // Bookkeeping.
  integer n_mismatch = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] q;
  reg err;
  reg [7:0] bexp [0:7];
  reg [15:0] iexp [0:3];
  reg [15:0] pe;

  crf_regfile crf_regfile_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .opcode_fetch_cycle(strb[0]),
    .rel_branch(strb[1]), .rel_disp(rel_disp), .pc_load(strb[2]),
    .pc_load_val(pc_load_val), .exchange_sets(strb[3]),
    .byte_we(strb[4]), .byte_sel(byte_sel), .byte_wdata(byte_wdata),
    .pair_we(strb[5]), .pair_kind(pair_kind), .pair_code(pair_code),
    .pair_half_en(pair_half_en), .pair_half_hi(pair_half_hi),
    .pair_wdata(pair_wdata), .flag_upd(strb[6]), .alu_kind(alu_kind),
    .alu_word(alu_word), .alu_a(alu_a), .alu_b(alu_b),
    .alu_res(alu_res), .rot_carry(rot_carry), .ea_req(strb[7]),
    .ea_mode(ea_mode), .ea_second_index(ea_second_index),
    .ea_disp(ea_disp), .ea_imm(ea_imm), .io_req(strb[8]),
    .io_form(io_form), .io_operand(io_operand), .vec_low(vec_low),
    .addr_out(addr_out), .addr_valid(addr_valid),
    .io_request_strobe_n(io_request_strobe_n), .vec_addr(vec_addr),
    .byte_rd(byte_rd), .pair_rd(pair_rd), .accum_out(accum_out),
    .condition_flags_out(condition_flags_out)
  );

  // Free-running 50 ns clock.
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end

  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end

  // Compares one value and counts it.
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer: setup, then access held until pready.
  task apb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    apb(1, a, d, q);
  endtask

  task rd(input [7:0] a, input [31:0] e);
    apb(0, a, 0, q);
    chk(q, e);
  endtask

  // Raises one core strobe for a cycle; called at a clock edge.
  task pulse(input integer k);
    strb <= 9'h1 << k;
    @(posedge pclk);
    strb <= 0;
    #1;
  endtask

  // One flag update, then the flag byte is read back under a mask.
  task flag(input [1:0] k, input w, input [15:0] a, input [15:0] b,
            input [15:0] r, input c, input [7:0] m, input [7:0] e);
    @(posedge pclk);
    alu_kind <= k;
    alu_word <= w;
    alu_a <= a;
    alu_b <= b;
    alu_res <= r;
    rot_carry <= c;
    pulse(6);
    apb(0, `CRF_OFF_AF, 0, q);
    chk(q & {24'h0, m}, {24'h0, e});
  endtask

  // Operand address request with its expected address.
  task ea(input [1:0] md, input s, input [7:0] d, input [15:0] e);
    @(posedge pclk);
    ea_mode <= md;
    ea_second_index <= s;
    ea_disp <= d;
    pulse(7);
    chk(addr_out, e);
    chk(addr_valid, 1);
  endtask

  // Prints the counts and the verdict, then stops.
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ******************************************
  // Main sequence.
  // ******************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, strb, rel_disp, byte_wdata,
     ea_disp, io_operand, byte_sel, pair_kind, pair_code, alu_kind,
     ea_mode, io_form, pair_half_en, pair_half_hi, alu_word, rot_carry,
     ea_second_index, pc_load_val, pair_wdata, alu_a, alu_b, alu_res} = '0;
    ea_imm = 16'hbeef;
    vec_low = 8'h44;
    bexp = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'h00, 8'ha5};
    iexp = '{16'h3c5a, 16'h3412, 16'h005a, 16'h0034};
    presetn = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    // Every register starts at zero.
    for (i = 0; i < 9; i++)
      rd(8'(i * 4), 0);
    wr(`CRF_OFF_AF, 32'ha5c2);
    wr(`CRF_OFF_BC, 32'h1234);
    wr(`CRF_OFF_DE, 32'h5678);
    wr(`CRF_OFF_HL, 32'h9abc);
    wr(`CRF_OFF_IX, 32'h1000);
    wr(`CRF_OFF_IY, 32'h2000);
    wr(`CRF_OFF_SP, 32'hfff0);
    // Byte selects; code 6 selects nothing.
    for (i = 0; i < 8; i++) if (i != 6) begin
      @(posedge pclk);
      byte_sel <= 3'(i);
      @(posedge pclk);
      #1;
      chk(byte_rd, bexp[i]);
    end
    // Every pair field kind and code; flag bits 5 and 3 are masked.
    for (i = 0; i < 16; i++) begin
      pe = (i[1:0] == 0) ? 16'h1234 : (i[1:0] == 1) ? 16'h5678 :
           (i[1:0] == 3) ? ((i[3:2] == 3) ? 16'ha5c2 : 16'hfff0) :
           (i[3:2] == 1) ? 16'h1000 : (i[3:2] == 2) ? 16'h2000 : 16'h9abc;
      @(posedge pclk);
      pair_kind <= i[3:2];
      pair_code <= i[1:0];
      @(posedge pclk);
      #1;
      chk(pair_rd & 16'hffd7, pe & 16'hffd7);
    end
    // Byte write to the accumulator, upper-half write to an index.
    @(posedge pclk);
    byte_sel <= `CRF_G_A;
    byte_wdata <= 8'h3c;
    pulse(4);
    rd(`CRF_OFF_AF, 32'h3cc2);
    chk(accum_out, 8'h3c);
    @(posedge pclk);
    pair_kind <= `CRF_KIND_FIRST;
    pair_code <= 2'h2;
    pair_half_en <= 1;
    pair_half_hi <= 1;
    pair_wdata <= 16'h0077;
    pulse(5);
    rd(`CRF_OFF_IX, 32'h7700);
    // Fetches advance the counter; its top bit stays put.
    for (i = 0; i < 3; i++) begin
      @(posedge pclk);
      pulse(0);
    end
    rd(`CRF_OFF_PC, 32'h0003);
    rd(`CRF_OFF_IR, 32'h0003);
    wr(`CRF_OFF_IR, 32'h12ff);
    @(posedge pclk);
    pulse(0);
    rd(`CRF_OFF_IR, 32'h1280);
    chk(vec_addr, 16'h1244);
    // Branch back by two, then a load.
    @(posedge pclk);
    rel_disp <= 8'hfe;
    pulse(1);
    rd(`CRF_OFF_PC, 32'h0002);
    @(posedge pclk);
    pc_load_val <= 16'h0100;
    pulse(2);
    // Operand address modes.
    ea(`CRF_EA_INDIRECT, 0, 8'h00, 16'h9abc);
    ea(`CRF_EA_IMMED, 0, 8'h00, 16'h0100);
    ea(`CRF_EA_INDEXED, 0, 8'h80, 16'h7680);
    ea(`CRF_EA_INDEXED, 1, 8'h7f, 16'h207f);
    ea(`CRF_EA_EXTENDED, 0, 8'h00, 16'hbeef);
    // All four I/O address forms.
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      io_form <= 2'(i);
      io_operand <= 8'h5a;
      pulse(8);
      chk(addr_out, iexp[i]);
      chk(io_request_strobe_n, 0);
    end
    // Flag updates: add, subtract, logic, rotate, word add.
    flag(0, 0, 16'h7f, 16'h01, 0, 0, 8'hd7, 8'h94);
    flag(1, 0, 16'h00, 16'h01, 0, 0, 8'hd7, 8'h93);
    flag(1, 0, 16'h80, 16'h01, 0, 0, 8'hd7, 8'h16);
    flag(0, 0, 16'h80, 16'h80, 0, 0, 8'hd7, 8'h45);
    flag(2, 0, 0, 0, 16'h00, 0, 8'hc4, 8'h44);
    flag(2, 0, 0, 0, 16'h07, 0, 8'hc4, 8'h00);
    flag(2, 0, 0, 0, 16'h81, 0, 8'hc4, 8'h84);
    flag(3, 0, 0, 0, 16'h00, 1, 8'h01, 8'h01);
    flag(0, 1, 16'h7fff, 16'h1, 0, 0, 8'h07, 8'h04);
    // Swap to the alternate set and back.
    @(posedge pclk);
    pulse(3);
    rd(`CRF_OFF_BC, 32'h0000);
    @(posedge pclk);
    pulse(3);
    rd(`CRF_OFF_BC, 32'h1234);
    // An unmapped offset is refused and reads zero.
    rd(8'h24, 32'h0);
    chk(err, 1);
    results;
  end
endmodule // crf_regfile_bench

bind crf_regfile crf_regfile_chk crf_regfile_chk_inst (
  .pclk(pclk), .presetn(presetn), .ea_req(ea_req), .ea_mode(ea_mode),
  .ea_imm(ea_imm), .io_req(io_req), .io_form(io_form),
  .io_operand(io_operand), .vec_low(vec_low), .flag_upd(flag_upd),
  .alu_kind(alu_kind), .alu_res(alu_res), .rot_carry(rot_carry),
  .addr_out(addr_out), .addr_valid(addr_valid),
  .io_request_strobe_n(io_request_strobe_n), .vec_addr(vec_addr),
  .condition_flags_out(condition_flags_out)
);
